// file: dv/egsrc_far_end.sv
`timescale 1ns/1ns
// far side: shared conversion clock source and a ganged partner device
module egsrc_far_end (
    // clock and commands
    input  wire logic clk_i,
    input  wire logic fire_i,
    input  wire logic clr_i,
    // pins
    input  wire logic sync_pin_i,
    output logic      conv_clk_o,
    output logic      sync_o,
    output int        edges_o
);
    logic prev;

    // odd start offset puts every clock edge 1 ns after a rising edge of clk_i
    initial begin
        conv_clk_o = 1'b0;
        sync_o     = 1'b0;
        edges_o    = 0;
        prev       = 1'b0;
        #37;
        forever #80 conv_clk_o = ~conv_clk_o;
    end

    // acting as master: one sync edge once the slave is enabled
    always @(posedge clk_i) if (fire_i) sync_o <= ~sync_o;

    // acting as slave: count every edge seen on the sync pin
    always @(posedge clk_i) begin
        prev <= sync_pin_i;
        if (clr_i) edges_o <= 0;
        else if (sync_pin_i !== prev) edges_o <= edges_o + 1;
    end
endmodule : egsrc_far_end

// file: dv/test_ecg_gang_sync_and_rate_control.sv
`timescale 1ns/1ns
module test_ecg_gang_sync_and_rate_control;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  ctl = 8'h00;
    logic        hp = 1'b1, sec_en = 1'b0, cal_en = 1'b0, fire = 1'b0, clr = 1'b0;
    logic [1:0]  rate = 2'h2, bw = 2'h0;
    logic [15:0] raw = 16'h0, trim = 16'h0;
    logic [3:0]  g_out = 4'h0, g_oe = 4'h0, gpo, gpoe;
    logic        ck_o, ck_oe, gs_o, gs_oe, cal_oe, sec_v, ov, conv, p_clk, p_sync;
    logic [15:0] sec_d;
    logic [23:0] ow;
    logic [19:0] lag, alag;
    wire         sync_pin = gs_oe ? gs_o : p_sync;
    int          fail_count = 0, checks_done = 0, n, e, seed;
    int          lag2k[4] = '{984000, 1915000, 2695000, 7641000};

    always #4 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        raw  <= 16'($urandom);
        trim <= 16'($urandom);
    end

    egsrc_top egsrc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ecg_control_register_i(ctl),
        .hp_mode_i(hp), .rate_sel_i(rate), .bw_sel_i(bw), .sec_port_en_i(sec_en),
        .cal_dac_out_en_i(cal_en), .raw_sample_i(raw), .gain_trim_i(trim), .conv_clk_in_i(p_clk),
        .conv_clk_out_o(ck_o), .conv_clk_oe_o(ck_oe), .gang_sync_in_i(sync_pin),
        .gang_sync_out_o(gs_o), .gang_sync_oe_o(gs_oe), .cal_dac_oe_o(cal_oe), .gpio_out_i(g_out),
        .gpio_oe_i(g_oe), .gpio_out_o(gpo), .gpio_oe_o(gpoe), .sec_valid_o(sec_v), .sec_data_o(sec_d),
        .out_valid_o(ov), .out_word_o(ow), .converting_o(conv), .lag_cycles_o(lag),
        .abs_lag_cycles_o(alag));

    egsrc_far_end egsrc_far_end_inst (.clk_i(clk_i), .fire_i(fire), .clr_i(clr),
        .sync_pin_i(sync_pin), .conv_clk_o(p_clk), .sync_o(p_sync), .edges_o(e));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic w(input int c);
        repeat (c) @(negedge clk_i);
    endtask : w

    // cycles between two pulses; the second gap avoids a restart after a change
    task automatic gap(input bit use_sec, output int c);
        repeat (2) begin
            c = 0;
            do begin
                @(posedge clk_i);
                #1;
                c++;
            end while ((use_sec ? sec_v : ov) !== 1'b1 && c < 40000);
        end
    endtask : gap

    task final_report;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    initial begin
        #600000;
        fail_count++;
        final_report();
    end

    initial begin
        seed = $urandom(32'hFBEB);
        w(12);
        rst_n_i = 1'b1;
        w(1);
        chk(gs_oe, 0);
        chk(ck_oe, 0);
        for (int r = 0; r < 4; r++) for (int b = 0; b < 4; b++) begin
            rate = r[1:0];
            bw   = b[1:0];
            w(3);
            n = (r == 1) ? 109000 : (r == 2) ? 0 : lag2k[b];
            chk(lag, n / 8);
            chk(alag, (n + 38000) / 8);
        end
        for (int i = 0; i < 4; i++) begin
            g_out  = 4'($urandom);
            g_oe   = 4'($urandom);
            sec_en = i[0];
            w(3);
            chk({gpo[3], gpoe[3]}, {g_out[3], g_oe[3]});
            if (!sec_en) chk({gpo, gpoe}, {g_out, g_oe});
            if (sec_en) chk(gpoe[2:0], 3'h7);
        end
        ctl = 8'h30;
        w(3);
        chk({gs_oe, ck_oe, cal_oe, conv}, 4'hC);
        cal_en = 1'b1;
        w(3);
        chk(cal_oe, 1);
        clr = 1'b1;
        w(1);
        clr = 1'b0;
        ctl = 8'h34;
        w(60);
        chk(e, 1);
        chk(conv, 1);
        // word spacing per rate and power mode, gang off, one device only
        ctl  = 8'h04;
        rate = 2'h1;
        sec_en = 1'b1;
        gap(1'b1, n);
        chk(n, 1280);
        gap(1'b0, n);
        chk(n, 10240);
        rate = 2'h2;
        hp   = 1'b0;
        gap(1'b0, n);
        chk(n, 1280);
        rst_n_i = 1'b0;
        w(4);
        chk({conv, ov, sec_v}, 3'h0);
        rst_n_i = 1'b1;
        ctl = 8'h30;
        w(3);
        chk(conv, 0);
        ctl = 8'h14;
        w(20);
        chk({conv, gs_oe, ck_oe}, 3'h0);
        fire = 1'b1;
        w(1);
        fire = 1'b0;
        w(8);
        chk(conv, 1);
        final_report();
    end
endmodule : test_ecg_gang_sync_and_rate_control

// file: include/egsrc_conv_if.sv
`timescale 1ns/1ns
// adc tick and raw sample path between rate control and decimator
interface egsrc_conv_if;
    logic                          adc_tick;
    logic                          hp_mode;
    logic [1:0]                    rate_sel;
    logic [1:0]                    bw_sel;
    logic                          flush;
    logic [egsrc_pkg::RAW_W-1:0]   raw_sample;
    logic                          out_valid;
    logic [egsrc_pkg::WORD_W-1:0]  out_word;
    logic                          raw_valid;

    modport ctl (output adc_tick, hp_mode, rate_sel, bw_sel, flush, raw_sample,
                 input out_valid, out_word, raw_valid);
    modport dec (input adc_tick, hp_mode, rate_sel, bw_sel, flush, raw_sample,
                 output out_valid, out_word, raw_valid);
endinterface : egsrc_conv_if

// file: include/egsrc_pkg.sv
package egsrc_pkg;
    // ecg control register bit positions
    localparam int CTL_CONV_BIT   = 2;
    localparam int CTL_GANG_BIT   = 4;
    localparam int CTL_MASTER_BIT = 5;
    localparam int CTL_WIDTH      = 8;

    // clocks and rates
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CLK_FREQ_KHZ   = 125000;
    localparam int CONV_CLK_KHZ   = 8192;
    localparam int ADC_HP_KHZ     = 2048;
    localparam int ADC_LP_KHZ     = 1024;
    localparam int ODR_128_KHZ    = 128;
    localparam int ODR_16_KHZ     = 16;
    localparam int ODR_2_KHZ      = 2;

    // conversion clock edges per adc sample
    localparam int HP_DIV = CONV_CLK_KHZ / ADC_HP_KHZ;
    localparam int LP_DIV = CONV_CLK_KHZ / ADC_LP_KHZ;

    // word widths
    localparam int WORD_W      = 24;
    localparam int USE_BITS_2K = 19;
    localparam int USE_BITS_16K = 18;
    localparam int RAW_W       = 16;

    // rate select and bandwidth select codes
    localparam logic [1:0] RATE_2K   = 2'h0;
    localparam logic [1:0] RATE_16K  = 2'h1;
    localparam logic [1:0] RATE_128K = 2'h2;
    localparam logic [1:0] BW_450    = 2'h0;
    localparam logic [1:0] BW_250    = 2'h1;
    localparam logic [1:0] BW_150    = 2'h2;
    localparam logic [1:0] BW_40     = 2'h3;

    // lag of ecg data behind pace flag, in ns
    localparam int LAG_2K_450_NS = 984000;
    localparam int LAG_2K_250_NS = 1915000;
    localparam int LAG_2K_150_NS = 2695000;
    localparam int LAG_2K_40_NS  = 7641000;
    localparam int LAG_16K_NS    = 109000;
    localparam int FIXED_LAG_NS  = 38000;

    // lag counts in clock cycles, rounded down
    localparam int LAG_2K_450_CYC = LAG_2K_450_NS / CLK_PERIOD_NS;
    localparam int LAG_2K_250_CYC = LAG_2K_250_NS / CLK_PERIOD_NS;
    localparam int LAG_2K_150_CYC = LAG_2K_150_NS / CLK_PERIOD_NS;
    localparam int LAG_2K_40_CYC  = LAG_2K_40_NS / CLK_PERIOD_NS;
    localparam int LAG_16K_CYC    = LAG_16K_NS / CLK_PERIOD_NS;
    localparam int FIXED_LAG_CYC  = FIXED_LAG_NS / CLK_PERIOD_NS;
    localparam int LAG_W          = 20;

    // gpio
    localparam int GPIO_N = 4;
    localparam logic [3:0] GPIO_SEC_MASK = 4'h7;
endpackage : egsrc_pkg

// file: rtl/egsrc_decim.sv
`timescale 1ns/1ns
// accumulate-and-dump decimator from adc rate down to the output rate
module egsrc_decim (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    // sample path
    egsrc_conv_if.dec  cv
);
    // adc samples per 128 kHz word: 16 in hp, 8 in lp
    localparam int HP_R = egsrc_pkg::ADC_HP_KHZ / egsrc_pkg::ODR_128_KHZ;
    localparam int LP_R = egsrc_pkg::ADC_LP_KHZ / egsrc_pkg::ODR_128_KHZ;
    localparam int R16  = egsrc_pkg::ODR_128_KHZ / egsrc_pkg::ODR_16_KHZ;
    localparam int R2   = egsrc_pkg::ODR_16_KHZ / egsrc_pkg::ODR_2_KHZ;

    logic [4:0]  s1_cnt;
    logic [19:0] s1_acc;
    logic [3:0]  s2_cnt;
    logic [22:0] s2_acc;
    logic [3:0]  s3_cnt;
    logic [25:0] s3_acc;
    logic        s1_done;
    logic        s2_done;
    logic        s3_done;
    logic [4:0]  s1_last;
    logic [2:0]  lp_shift;
    logic [15:0] w128;
    logic [23:0] w16;
    logic [23:0] w2;

    assign s1_last = cv.hp_mode ? 5'(HP_R - 1) : 5'(LP_R - 1);
    assign s1_done = cv.adc_tick && (s1_cnt == s1_last);
    assign s2_done = s1_done && (s2_cnt == 4'(R16 - 1));
    assign s3_done = s2_done && (s3_cnt == 4'(R2 - 1));
    // lp mode sums half as many samples, so scale up by one bit
    assign lp_shift = cv.hp_mode ? 3'h4 : 3'h3;
    assign w128 = 16'((s1_acc + 20'(cv.raw_sample)) >> lp_shift);
    // narrower stages carry fewer usable bits; low bits kept zero
    assign w16  = {23'((s2_acc + 23'(w128)) >> 3) & 23'h7FFFFF, 1'h0} &
                  ~24'((1 << (24 - egsrc_pkg::USE_BITS_16K)) - 1);
    assign w2   = 24'((s3_acc + 26'(w16[23:8])) >> 3) << 5 &
                  ~24'((1 << (24 - egsrc_pkg::USE_BITS_2K)) - 1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cv.flush) begin
            s1_cnt <= 5'h00;
            s1_acc <= 20'h00000;
            s2_cnt <= 4'h0;
            s2_acc <= 23'h000000;
            s3_cnt <= 4'h0;
            s3_acc <= 26'h0000000;
        end else if (cv.adc_tick) begin
            s1_cnt <= s1_done ? 5'h00 : s1_cnt + 5'h01;
            s1_acc <= s1_done ? 20'h00000 : s1_acc + 20'(cv.raw_sample);
            if (s1_done) begin
                s2_cnt <= s2_done ? 4'h0 : s2_cnt + 4'h1;
                s2_acc <= s2_done ? 23'h000000 : s2_acc + 23'(w128);
            end
            if (s2_done) begin
                s3_cnt <= s3_done ? 4'h0 : s3_cnt + 4'h1;
                s3_acc <= s3_done ? 26'h0000000 : s3_acc + 26'(w16[23:8]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cv.flush) begin
            cv.out_valid <= 1'b0;
            cv.out_word  <= 24'h000000;
            cv.raw_valid <= 1'b0;
        end else begin
            cv.raw_valid <= s1_done;
            case (cv.rate_sel)
                egsrc_pkg::RATE_128K: begin
                    cv.out_valid <= s1_done;
                    if (s1_done) cv.out_word <= {w128, 8'h00};
                end
                egsrc_pkg::RATE_16K: begin
                    cv.out_valid <= s2_done;
                    if (s2_done) cv.out_word <= w16;
                end
                default: begin
                    cv.out_valid <= s3_done;
                    if (s3_done) cv.out_word <= w2;
                end
            endcase
        end
    end

    s1_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cv.adc_tick && !cv.flush && s1_cnt != s1_last |=> s1_cnt == $past(s1_cnt) + 5'h01)
        else $error("decimator stage count did not advance");
endmodule : egsrc_decim

// file: rtl/egsrc_top.sv
`timescale 1ns/1ns
// Operation
// - secondary port, when enabled, masters out samples at 128 kHz only.
// - secondary port takes three gpio pins, one gpio stays usable.
// - secondary port samples bypass channel gain-matching calibration.
// - adc samples at 2.048 MHz high performance, 1.024 MHz low power.
// - output rate selectable 128, 16 or 2 kHz, more decimation lower.
// - 2 and 16 kHz words are 24 bits, 19 and 18 usable.
// - 2 kHz rate offers 450, 250, 150 and 40 Hz bandwidths; here bw_sel_i only changes the reported lag, the decimator ignores it.
// - reset clears all decimation and low-pass filter state.
// - data lags pace flag: bandwidth-dependent at 2 kHz, 109 us, or zero.
// - add a fixed 38 us to the lag for absolute delay.
// - control bit 5 selects gang master versus slave.
// - control bit 4 enables gang operation.
// - master turns gang sync pin into a driven output.
// - slave keeps gang sync and shared clock pins as inputs.
// - shared clock and gang sync pins stay high-z until gang enabled.
// - master emits exactly one sync edge on conversion enable.
// - calibration dac routing is never automatic in gang mode.
module egsrc_top (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    // ecg control register and configuration
    input  wire logic [egsrc_pkg::CTL_WIDTH-1:0]    ecg_control_register_i,
    input  wire logic                               hp_mode_i,
    input  wire logic [1:0]                         rate_sel_i,
    input  wire logic [1:0]                         bw_sel_i,
    input  wire logic                               sec_port_en_i,
    input  wire logic                               cal_dac_out_en_i,
    // adc raw samples and gain trim
    input  wire logic [egsrc_pkg::RAW_W-1:0]        raw_sample_i,
    input  wire logic [egsrc_pkg::RAW_W-1:0]        gain_trim_i,
    // shared conversion clock pin
    input  wire logic                               conv_clk_in_i,
    output logic                                    conv_clk_out_o,
    output logic                                    conv_clk_oe_o,
    // gang sync pin
    input  wire logic                               gang_sync_in_i,
    output logic                                    gang_sync_out_o,
    output logic                                    gang_sync_oe_o,
    // calibration dac pin
    output logic                                    cal_dac_oe_o,
    // gpio pins
    input  wire logic [egsrc_pkg::GPIO_N-1:0]       gpio_out_i,
    input  wire logic [egsrc_pkg::GPIO_N-1:0]       gpio_oe_i,
    output logic [egsrc_pkg::GPIO_N-1:0]            gpio_out_o,
    output logic [egsrc_pkg::GPIO_N-1:0]            gpio_oe_o,
    // secondary data port
    output logic                                    sec_valid_o,
    output logic [egsrc_pkg::RAW_W-1:0]             sec_data_o,
    // main data path
    output logic                                    out_valid_o,
    output logic [egsrc_pkg::WORD_W-1:0]            out_word_o,
    output logic                                    converting_o,
    output logic [egsrc_pkg::LAG_W-1:0]             lag_cycles_o,
    output logic [egsrc_pkg::LAG_W-1:0]             abs_lag_cycles_o
);
    typedef enum logic [1:0] {EGSRC_IDLE, EGSRC_WAIT_SYNC, EGSRC_RUN} egsrc_state_e;

    egsrc_state_e state;
    egsrc_state_e next_state;
    egsrc_conv_if cv ();

    // control bit decode
    wire conv_en   = ecg_control_register_i[egsrc_pkg::CTL_CONV_BIT];
    wire gang_en   = ecg_control_register_i[egsrc_pkg::CTL_GANG_BIT];
    wire master_en = ecg_control_register_i[egsrc_pkg::CTL_MASTER_BIT];
    wire is_master = gang_en && master_en;
    wire is_slave  = gang_en && !master_en;

    // pin synchronisers
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clk_s1  <= 1'b0;
            clk_s2  <= 1'b0;
            clk_s3  <= 1'b0;
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
        end else begin
            clk_s1  <= conv_clk_in_i;
            clk_s2  <= clk_s1;
            clk_s3  <= clk_s2;
            sync_s1 <= gang_sync_in_i;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end
    wire conv_clk_rise = clk_s2 && !clk_s3;
    // either polarity counts: the master sends one edge per conversion start
    wire sync_edge     = sync_s2 ^ sync_s3;

    // conversion clock: slaves use the pin, master uses it too when fed externally
    // trade-off: 125 MHz sampling limits the shared clock to well under 62 MHz
    logic [2:0] conv_div;
    logic [2:0] div_last;
    assign div_last = hp_mode_i ? 3'(egsrc_pkg::HP_DIV - 1) : 3'(egsrc_pkg::LP_DIV - 1);
    wire adc_tick = (state == EGSRC_RUN) && conv_clk_rise && (conv_div == div_last);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != EGSRC_RUN) begin
            conv_div <= 3'h0;
        end else if (conv_clk_rise) begin
            conv_div <= (conv_div == div_last) ? 3'h0 : conv_div + 3'h1;
        end
    end

    // gang state: slave waits for master edge before converting
    always_comb begin
        next_state = state;
        case (state)
            EGSRC_IDLE: begin
                if (conv_en) next_state = is_slave ? EGSRC_WAIT_SYNC : EGSRC_RUN;
            end
            EGSRC_WAIT_SYNC: begin
                if (!conv_en) next_state = EGSRC_IDLE;
                else if (sync_edge) next_state = EGSRC_RUN;
            end
            EGSRC_RUN: begin
                if (!conv_en) next_state = EGSRC_IDLE;
            end
            default: next_state = EGSRC_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) state <= EGSRC_IDLE;
        else state <= next_state;
    end

    // master toggles sync once per conversion start
    logic sync_level;
    wire  start_conv = (state == EGSRC_IDLE) && (next_state == EGSRC_RUN);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) sync_level <= 1'b0;
        else if (start_conv && is_master) sync_level <= ~sync_level;
    end

    // pin drivers; slave and non-gang leave gang pins undriven, cal dac pin follows its enable
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gang_sync_oe_o  <= 1'b0;
            gang_sync_out_o <= 1'b0;
            conv_clk_oe_o   <= 1'b0;
            conv_clk_out_o  <= 1'b0;
            cal_dac_oe_o    <= 1'b0;
        end else begin
            gang_sync_oe_o  <= is_master;
            gang_sync_out_o <= sync_level;
            // master forwards the conversion clock it receives to the slaves
            conv_clk_oe_o   <= is_master;
            conv_clk_out_o  <= clk_s2;
            cal_dac_oe_o    <= cal_dac_out_en_i;
        end
    end

    // decimation path
    assign cv.adc_tick   = adc_tick;
    assign cv.hp_mode    = hp_mode_i;
    assign cv.rate_sel   = rate_sel_i;
    assign cv.bw_sel     = bw_sel_i;
    // filters flush on leaving run so a restart starts clean
    assign cv.flush      = (state != EGSRC_RUN);
    assign cv.raw_sample = raw_sample_i;

    egsrc_decim u_decim (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cv      (cv.dec)
    );

    // gain trim applies to the main path only
    logic [31:0] trim_prod;
    assign trim_prod = 32'(cv.out_word[23:8]) * 32'(gain_trim_i);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_valid_o  <= 1'b0;
            out_word_o   <= 24'h000000;
            converting_o <= 1'b0;
        end else begin
            out_valid_o  <= cv.out_valid;
            // top 24 bits of the trimmed product; the secondary port carries raw adc samples instead
            if (cv.out_valid) out_word_o <= trim_prod[31:8];
            converting_o <= (state == EGSRC_RUN);
        end
    end

    // secondary port: raw adc sample, loaded on each 128 kHz stage dump, uncalibrated
    logic [egsrc_pkg::RAW_W-1:0] raw_hold;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sec_valid_o <= 1'b0;
            sec_data_o  <= 16'h0000;
        end else begin
            sec_valid_o <= sec_port_en_i && cv.raw_valid;
            if (cv.raw_valid) sec_data_o <= raw_hold;
        end
    end
    // register of the raw adc input sample, cleared outside run
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != EGSRC_RUN) raw_hold <= 16'h0000;
        else raw_hold <= raw_sample_i;
    end

    // gpio: three pins go to the secondary port, the fourth stays with software
    genvar g;
    generate
        for (g = 0; g < egsrc_pkg::GPIO_N; g++) begin : g_gpio
            wire taken = sec_port_en_i && egsrc_pkg::GPIO_SEC_MASK[g];
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    gpio_out_o[g] <= 1'b0;
                    gpio_oe_o[g]  <= 1'b0;
                end else begin
                    gpio_out_o[g] <= taken ? (g == 0 ? sec_valid_o : sec_data_o[g]) : gpio_out_i[g];
                    gpio_oe_o[g]  <= taken ? 1'b1 : gpio_oe_i[g];
                end
            end
        end
    endgenerate

    // pace-to-data lag, in clock cycles
    logic [egsrc_pkg::LAG_W-1:0] lag_2k;
    always_comb begin
        case (bw_sel_i)
            egsrc_pkg::BW_450: lag_2k = 20'(egsrc_pkg::LAG_2K_450_CYC);
            egsrc_pkg::BW_250: lag_2k = 20'(egsrc_pkg::LAG_2K_250_CYC);
            egsrc_pkg::BW_150: lag_2k = 20'(egsrc_pkg::LAG_2K_150_CYC);
            default:           lag_2k = 20'(egsrc_pkg::LAG_2K_40_CYC);
        endcase
    end
    wire [egsrc_pkg::LAG_W-1:0] lag_sel =
        (rate_sel_i == egsrc_pkg::RATE_128K) ? 20'h00000 :
        (rate_sel_i == egsrc_pkg::RATE_16K)  ? 20'(egsrc_pkg::LAG_16K_CYC) : lag_2k;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lag_cycles_o     <= 20'h00000;
            abs_lag_cycles_o <= 20'h00000;
        end else begin
            lag_cycles_o     <= lag_sel;
            abs_lag_cycles_o <= lag_sel + 20'(egsrc_pkg::FIXED_LAG_CYC);
        end
    end

    // assertions
    sequence master_start_s;
        is_master && start_conv;
    endsequence
    sequence one_toggle_s;
        ##2 gang_sync_out_o != $past(gang_sync_out_o);
    endsequence

    sync_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        master_start_s |-> one_toggle_s)
        else $error("master start gave no sync edge");
    sync_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == EGSRC_RUN && $past(state) == EGSRC_RUN |-> $stable(sync_level))
        else $error("sync toggled while running");
    slave_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == EGSRC_WAIT_SYNC && conv_en && !sync_edge |=> state == EGSRC_WAIT_SYNC)
        else $error("slave started without sync edge");
    slave_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == EGSRC_WAIT_SYNC && conv_en && sync_edge |=> state == EGSRC_RUN)
        else $error("slave missed sync edge");
    pin_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !gang_en [*2] |-> !gang_sync_oe_o && !conv_clk_oe_o)
        else $error("gang pins driven outside gang mode");
    master_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        is_master |=> gang_sync_oe_o)
        else $error("master sync pin not driven");
    slave_in_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        is_slave |=> !gang_sync_oe_o && !conv_clk_oe_o)
        else $error("slave drives gang pins");
    sec_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sec_valid_o |-> $past(cv.raw_valid) && $past(sec_port_en_i))
        else $error("secondary word off the 128 kHz grid");
    abs_lag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> abs_lag_cycles_o == lag_cycles_o + 20'(egsrc_pkg::FIXED_LAG_CYC))
        else $error("absolute lag missing fixed term");
    gpio_free_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> gpio_out_o[3] == $past(gpio_out_i[3]))
        else $error("free gpio taken by secondary port");
endmodule : egsrc_top
